/* shared/sbr_pkg.sv */
// Purpose: constants for the serial bit-rate generator
// Assumes: 8-bit register port, byte offsets as printed
// Notes:   shared by the design and the bench side
package sbr_pkg;
    // register offsets
    localparam logic [2:0] SBR_OFS_BIT_RATE_CTRL = 3'h2;
    localparam logic [2:0] SBR_OFS_FLAG_STATUS   = 3'h3;

    // bit-rate control fields
    localparam int         SBR_RSVD_BIT    = 7;
    localparam int         SBR_PRESC_LSB   = 4;
    localparam int         SBR_PRESC_W     = 3;
    localparam int         SBR_RATE_LSB    = 0;
    localparam int         SBR_RATE_W      = 4;
    localparam logic [3:0] SBR_RATE_MAX    = 4'h8;
    localparam logic [7:0] SBR_CTRL_RESET  = 8'h00;
    localparam logic [7:0] SBR_CTRL_WMASK  = 8'h7f;

    // flag status layout: low nibble not implemented
    localparam int         SBR_FLAG_LSB    = 4;
    localparam int         SBR_FLAG_W      = 4;
    localparam logic [3:0] SBR_FLAG_UNIMPL = 4'h0;

    // answer for an unmapped read and idle read data
    localparam logic [7:0] SBR_RD_IDLE     = 8'h00;

    // divider widths: prescaler up to 8, half period up to 256
    localparam int         SBR_PRE_CNT_W   = 3;
    localparam int         SBR_HALF_CNT_W  = 8;
endpackage : sbr_pkg

/* rtl/sbr_bit_rate_gen.sv */
// Purpose: bit-rate generator and flag register shell for a serial master
// Assumes: one clock, register port strobes synchronous to CLK
// Notes:   serial clock runs only while MASTER_MODE is high
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
// Summary of operation
// [RULE_01] bit 7 of bit-rate control is reserved, read-only, reads zero
// [RULE_02] prescale field bits 6..4 divides by its value plus one
// [RULE_03] prescaler runs from bus clock and alone feeds the rate divider
// [RULE_04] rate field bits 3..0 divides by two to field plus one
// [RULE_05] flag register is read-only; writes do nothing at all
// [RULE_06] flag register bits 3..0 unimplemented and read zero
// [RULE_07] bit-rate control may be read or written at any time
// [RULE_08] divisors drive the serial clock only in master mode
// [RULE_09] serial clock is bus clock over both divisors, balanced phases
module sbr_bit_rate_gen
    import sbr_pkg::*;
#(
    parameter int DATA_W = 8
) (
    input  wire logic              CLK,
    input  wire logic              RST_N,
    input  wire logic [2:0]        ADDR,
    input  wire logic [DATA_W-1:0] WR_DATA,
    input  wire logic              WR_STB,
    input  wire logic              RD_STB,
    output logic      [DATA_W-1:0] RD_DATA,
    input  wire logic              MASTER_MODE,
    input  wire logic [3:0]        FLAG_IN,
    output logic                   BIT_CLK,
    output logic                   BIT_TICK
);

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // effective rate code; reserved codes above eight act as eight
    function automatic logic [SBR_RATE_W-1:0] rate_code(
        input logic [SBR_RATE_W-1:0] code
    );
        rate_code = (code > SBR_RATE_MAX) ? SBR_RATE_MAX : code;
    endfunction : rate_code

    // ticks per half period of the serial clock, minus one
    function automatic logic [SBR_HALF_CNT_W-1:0] half_limit(
        input logic [SBR_RATE_W-1:0] code
    );
        logic [SBR_HALF_CNT_W:0] ones;
        ones = (SBR_HALF_CNT_W+1)'(1) << rate_code(code);
        half_limit = SBR_HALF_CNT_W'(ones - (SBR_HALF_CNT_W+1)'(1));
    endfunction : half_limit

    // address match for one register offset
    function automatic logic addr_hit(
        input logic [2:0] addr,
        input logic [2:0] ofs
    );
        addr_hit = (addr == ofs);
    endfunction : addr_hit

    ////////////////////////////////////////////////////////////////////////
    // address decode

    // qualified strobes, one per register access kind
    logic                      wr_ctrl;
    logic                      rd_ctrl;
    logic                      rd_flag;

    // strobes qualified by offset; the flag offset has no write path,
    // so a write there or to an unmapped offset simply falls away
    assign wr_ctrl = WR_STB &&                                  // RULE_07
                     addr_hit(ADDR, SBR_OFS_BIT_RATE_CTRL);
    assign rd_ctrl = RD_STB &&
                     addr_hit(ADDR, SBR_OFS_BIT_RATE_CTRL);
    assign rd_flag = RD_STB &&
                     addr_hit(ADDR, SBR_OFS_FLAG_STATUS);

    ////////////////////////////////////////////////////////////////////////
    // bit-rate control register

    // stored control byte and its next value
    logic [7:0]                ctrl_reg;
    logic [7:0]                ctrl_next;

    // write lands in any divider state; reserved bit dropped on entry
    always_comb begin
        ctrl_next = ctrl_reg;
        if (wr_ctrl) begin                                      // RULE_07
            ctrl_next = WR_DATA[7:0] & SBR_CTRL_WMASK;          // RULE_01
        end else begin
            ctrl_next = ctrl_reg;
        end
    end

    // control register, cleared by reset
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ctrl_reg <= SBR_CTRL_RESET;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    // divisor fields and the software view of control
    logic [SBR_PRESC_W-1:0]    presc_sel;
    logic [SBR_RATE_W-1:0]     rate_sel;
    logic [SBR_RATE_W-1:0]     rate_eff;
    logic [7:0]                ctrl_view;

    // fields are read straight from the register, so a change
    // reaches the dividers in the cycle after the write
    assign presc_sel = ctrl_reg[SBR_PRESC_LSB +: SBR_PRESC_W];  // RULE_02
    assign rate_sel  = ctrl_reg[SBR_RATE_LSB +: SBR_RATE_W];    // RULE_04
    assign ctrl_view = ctrl_reg & SBR_CTRL_WMASK;               // RULE_01

    // reserved rate codes read back as written but divide as the top code
    assign rate_eff  = rate_code(rate_sel);                     // RULE_04

    ////////////////////////////////////////////////////////////////////////
    // flag status shell

    // upper flag copy and the assembled read view
    logic [SBR_FLAG_W-1:0]     flag_reg;
    logic [SBR_FLAG_W-1:0]     flag_next;
    logic [7:0]                flag_view;

    // upper flags follow the shift logic; no register write reaches them
    always_comb begin
        flag_next = FLAG_IN;                                    // RULE_05
    end

    // flag copy register
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            flag_reg <= SBR_FLAG_UNIMPL;
        end else begin
            flag_reg <= flag_next;
        end
    end

    // low nibble is not implemented and reads zero
    assign flag_view = {flag_reg, SBR_FLAG_UNIMPL};             // RULE_06

    ////////////////////////////////////////////////////////////////////////
    // read answer

    // registered read data
    logic [DATA_W-1:0]         rd_data_reg;
    logic [DATA_W-1:0]         rd_data_next;

    // answer stands one cycle after the strobe, else idle;
    // unmapped offsets answer with the idle value
    always_comb begin
        rd_data_next = DATA_W'(SBR_RD_IDLE);
        if (rd_ctrl) begin
            rd_data_next = DATA_W'(ctrl_view);
        end else if (rd_flag) begin
            rd_data_next = DATA_W'(flag_view);
        end else begin
            rd_data_next = DATA_W'(SBR_RD_IDLE);
        end
    end

    // read data register
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rd_data_reg <= DATA_W'(SBR_RD_IDLE);
        end else begin
            rd_data_reg <= rd_data_next;
        end
    end

    assign RD_DATA = rd_data_reg;

    ////////////////////////////////////////////////////////////////////////
    // prescaler

    // bus clock counter and its strobe
    logic [SBR_PRE_CNT_W-1:0]  pre_cnt_reg;
    logic [SBR_PRE_CNT_W-1:0]  pre_cnt_next;
    logic                      pre_tick;

    // strobe once every presc_sel+1 bus clocks; >= ends a count
    // that a lowered prescale setting has already overtaken
    assign pre_tick = (pre_cnt_reg >= presc_sel);               // RULE_02

    // count bus clocks; held cleared outside master mode
    always_comb begin
        pre_cnt_next = pre_cnt_reg;
        if (!MASTER_MODE) begin                                 // RULE_08
            pre_cnt_next = '0;
        end else if (pre_tick) begin                            // RULE_03
            pre_cnt_next = '0;
        end else begin
            pre_cnt_next = pre_cnt_reg + 1'b1;
        end
    end

    // prescaler counter register
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            pre_cnt_reg <= '0;
        end else begin
            pre_cnt_reg <= pre_cnt_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // rate divider

    // prescaler strobe counter within one half period
    logic [SBR_HALF_CNT_W-1:0] half_cnt_reg;
    logic [SBR_HALF_CNT_W-1:0] half_cnt_next;
    logic [SBR_HALF_CNT_W-1:0] half_lim;
    logic                      half_wrap;

    // half period end; only prescaler strobes advance the divider,
    // and >= also ends a half period cut short by a lowered limit
    assign half_lim  = half_limit(rate_eff);                    // RULE_04
    assign half_wrap = MASTER_MODE && pre_tick &&               // RULE_03
                       (half_cnt_reg >= half_lim);

    // count prescaler strobes; cleared at each wrap and as slave
    always_comb begin
        half_cnt_next = half_cnt_reg;
        if (!MASTER_MODE) begin                                 // RULE_08
            half_cnt_next = '0;
        end else if (half_wrap) begin
            half_cnt_next = '0;
        end else if (pre_tick) begin
            half_cnt_next = half_cnt_reg + 1'b1;
        end else begin
            half_cnt_next = half_cnt_reg;
        end
    end

    // rate divider counter register
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            half_cnt_reg <= '0;
        end else begin
            half_cnt_reg <= half_cnt_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // serial clock

    // serial clock level
    logic                      bit_clk_reg;
    logic                      bit_clk_next;

    // toggle at each half period end; equal halves give a balanced
    // clock; forced low outside master mode
    always_comb begin
        bit_clk_next = bit_clk_reg;
        if (!MASTER_MODE) begin                                 // RULE_08
            bit_clk_next = 1'b0;
        end else if (half_wrap) begin                           // RULE_09
            bit_clk_next = ~bit_clk_reg;
        end else begin
            bit_clk_next = bit_clk_reg;
        end
    end

    // serial clock register, idles low
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            bit_clk_reg <= 1'b0;
        end else begin
            bit_clk_reg <= bit_clk_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // serial tick

    // one-cycle marker beside each clock edge
    logic                      tick_reg;
    logic                      tick_next;

    // tick marks the same cycle as each toggle
    always_comb begin
        tick_next = half_wrap;                                  // RULE_09
    end

    // tick register
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            tick_reg <= 1'b0;
        end else begin
            tick_reg <= tick_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    // both serial outputs come straight from flip-flops
    assign BIT_CLK  = bit_clk_reg;
    assign BIT_TICK = tick_reg;

endmodule : sbr_bit_rate_gen

/* dv/sbr_shift_model.sv */
// Purpose: shift logic stand-in feeding the upper flag bits
// Assumes: flags step once per serial clock tick
// Notes:   gives the flag register a moving pattern
`timescale 1ns/1ps
module sbr_shift_model (
    input  wire logic       CLK,
    input  wire logic       RST_N,
    input  wire logic       BIT_TICK,
    output logic      [3:0] FLAGS
);
    // flags advance by a fixed step on every serial tick
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) FLAGS <= 4'h5;
        else if (BIT_TICK) FLAGS <= FLAGS + 4'h3;
    end
endmodule : sbr_shift_model

/* dv/sbr_bit_rate_gen_checker.sv */
// Purpose: port assertions for the bit-rate generator
// Assumes: one clock domain, strobes never together
// Notes:   bound to every generator instance
`timescale 1ns/1ps
module sbr_bit_rate_gen_checker
    import sbr_pkg::*;
(
    input wire logic       CLK,
    input wire logic       RST_N,
    input wire logic [2:0] ADDR,
    input wire logic       RD_STB,
    input wire logic [7:0] RD_DATA,
    input wire logic       MASTER_MODE,
    input wire logic [3:0] FLAG_IN,
    input wire logic       BIT_CLK,
    input wire logic       BIT_TICK
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    a_rd_idle_zero: assert property (
        !$past(RD_STB) |-> RD_DATA == SBR_RD_IDLE)
        else $error("read data not idle");
    a_rsvd_bit_zero: assert property (
        $past(RD_STB) && $past(ADDR) == SBR_OFS_BIT_RATE_CTRL
        |-> !RD_DATA[SBR_RSVD_BIT]) else $error("bit 7 set");
    a_flag_low_zero: assert property (
        $past(RD_STB) && $past(ADDR) == SBR_OFS_FLAG_STATUS
        |-> RD_DATA[3:0] == SBR_FLAG_UNIMPL) else $error("low flags");
    a_flag_copy: assert property (
        RD_STB && ADDR == SBR_OFS_FLAG_STATUS && $stable(FLAG_IN)
        |=> RD_DATA[7:4] == $past(FLAG_IN)) else $error("flag copy");
    a_slave_idle: assert property (
        !MASTER_MODE |=> !BIT_CLK && !BIT_TICK)
        else $error("clock runs as slave");
    a_tick_toggles: assert property (
        BIT_TICK |-> $changed(BIT_CLK)) else $error("tick without toggle");
    a_toggle_ticks: assert property (
        $changed(BIT_CLK) && $past(MASTER_MODE) |-> BIT_TICK)
        else $error("toggle without tick");
    a_tick_master: assert property (
        BIT_TICK |-> $past(MASTER_MODE)) else $error("tick while idle");
endmodule : sbr_bit_rate_gen_checker
bind sbr_bit_rate_gen sbr_bit_rate_gen_checker u_chk (.CLK(CLK), .RST_N(RST_N),
    .ADDR(ADDR), .RD_STB(RD_STB), .RD_DATA(RD_DATA), .MASTER_MODE(MASTER_MODE),
    .FLAG_IN(FLAG_IN), .BIT_CLK(BIT_CLK), .BIT_TICK(BIT_TICK));

/* dv/sbr_bit_rate_gen_tb.sv */
// Purpose: self-check of the bit-rate generator
// Assumes: 50 MHz CLK, control model held in c
// Notes:   sweeps every prescale code and rate codes 0 to 9
`timescale 1ns/1ps
module sbr_bit_rate_gen_tb;
    import sbr_pkg::*;
    logic        clk, rst_n, wr, rd, mm, bclk, tick;
    logic [2:0]  a;
    logic [7:0]  wd, q, c;
    logic [3:0]  fl;
    logic [11:0] h;
    logic [31:0] s;
    int          num_errors, checks_done, cyc, n;
    sbr_bit_rate_gen DUT (.CLK(clk), .RST_N(rst_n), .ADDR(a), .WR_DATA(wd),
        .WR_STB(wr), .RD_STB(rd), .RD_DATA(q), .MASTER_MODE(mm),
        .FLAG_IN(fl), .BIT_CLK(bclk), .BIT_TICK(tick));
    sbr_shift_model PEER (.CLK(clk), .RST_N(rst_n), .BIT_TICK(tick),
        .FLAGS(fl));
    // bus clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr
    task automatic chk(input string w, input logic [11:0] e, g);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", w, e, g);
        end
    endtask : chk
    task automatic acc(input logic w, input logic [2:0] x,
        input logic [7:0] d);
        @(posedge clk) {a, wd, wr, rd} <= {x, d, w, !w};
        @(posedge clk) {wr, rd} <= 2'b00;
        #1 if (!w) chk("read data", {4'h0, d}, {4'h0, q});
    endtask : acc
    task automatic final_report;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : final_report
    // cycle ceiling against a hung divider
    always @(posedge clk) begin
        cyc++;
        if (cyc == 90000) begin
            num_errors++;
            final_report();
        end
    end
    // reset, register access, then the divisor sweep
    initial begin
        {rst_n, wr, rd, mm, a, wd} = '0;
        s = 32'h34d34243;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        acc(0, SBR_OFS_BIT_RATE_CTRL, 8'h00);
        acc(1, SBR_OFS_FLAG_STATUS, 8'hff);
        acc(0, SBR_OFS_FLAG_STATUS, {fl, 4'h0});
        acc(1, 3'h5, 8'hff);
        acc(0, 3'h5, 8'h00);
        acc(0, SBR_OFS_BIT_RATE_CTRL, 8'h00);
        for (int p = 0; p < 8; p++) begin
            for (int r = 0; r < 10; r++) begin
                s = lfsr(s);
                c = {1'b0, p[2:0], r[3:0]};
                acc(1, SBR_OFS_BIT_RATE_CTRL, c | {s[0], 7'h0});
                acc(0, SBR_OFS_BIT_RATE_CTRL, c);
                @(posedge clk) mm <= 1'b0;
                @(posedge clk) mm <= 1'b1;
                #1 chk("idle clock", 12'h0, {11'h0, bclk});
                h = 12'(p + 1) << (r > 8 ? 8 : r);
                for (int k = 1; k >= 0; k--) begin
                    n = 0;
                    do begin
                        @(posedge clk);
                        #1 n++;
                    end while (tick !== 1'b1 && n < 4096);
                    chk("half period", h, n[11:0]);
                    chk("clock level", 12'(k), {11'h0, bclk});
                end
            end
        end
        final_report();
    end
endmodule : sbr_bit_rate_gen_tb
